// ---- design/sequencer_slots_pkg.sv ----
package sequencer_slots_pkg;
  // slot register map
  localparam logic [7:0] FIRST_SLOT_ADDR = 8'h0f;
  localparam logic [7:0] TRIGGER_ADDR = 8'h0c;
  localparam logic [7:0] SLOT_SIX_ADDR = 8'h14;
  localparam logic [7:0] SLOT_SEVEN_ADDR = 8'h15;
  localparam logic [7:0] LAST_SLOT_ADDR = 8'h16;
  localparam int SLOT_COUNT = 8;
  // slot field layout
  localparam int DELAY_FLAG_BIT = 7;
  localparam int VALUE_MSB = 6;
  localparam logic [7:0] SLOT_RESET = 8'h00;
  // idle step timing
  localparam longint CLOCK_HZ = 20_000_000;
  localparam longint DELAY_STEP_MS = 10;
  localparam longint STEP_CYCLES = (CLOCK_HZ * DELAY_STEP_MS) / 1000;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_PLAY = 4'b0100,
    ST_WAIT = 4'b1000
  } seq_state_t;
endpackage

// ---- design/waveform_sequencer_slots.sv ----
`timescale 1ns/1ps
// Overview of operation
// [R1] flag set: slot value is idle time
// [R2] idle lasts value times 10 ms
// [R3] flag clear: slot value is effect index
// [R4] index selects library waveform by position
// [R5] trigger starts playback at first slot
// [R6] after each slot, advance to next slot
// [R7] stop at zero identifier or eighth slot
// [R8] flag and value read/write, reset zero
// [R9] prescaler makes 10 ms steps, counts down
module waveform_sequencer_slots
  import sequencer_slots_pkg::*;
#(
  parameter int STEP_LEN = int'(STEP_CYCLES)
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic playback_trigger,
  input wire logic effect_done,
  output logic effect_start,
  output logic [6:0] effect_index,
  output logic engine_idling,
  output logic sequence_busy,
  output logic [2:0] slot_pointer
);

  //////////////////////////////////////////////////////////////////////
  // storage and state
  logic [7:0] slot_reg [SLOT_COUNT]; // all eight sequence slots
  seq_state_t state_reg; // sequencer state
  logic busy_reg; // sequence running, flop behind the busy pin
  logic [2:0] ptr_reg; // current slot position
  logic [6:0] delay_reg; // idle steps left
  logic [31:0] prescale_reg; // cycles left in this step
  logic effect_start_reg; // one-cycle effect launch
  logic [6:0] effect_index_reg; // library position to play
  logic [7:0] rdata_reg; // read data
  logic [7:0] cur_slot; // slot under the pointer
  logic slot_hit; // address falls on a slot
  logic [2:0] slot_sel; // slot chosen by address
  logic step_tick; // end of one idle step
  logic [7:0] addr_off; // address minus first slot

  // slot under the pointer
  assign cur_slot = slot_reg[ptr_reg];
  // address decode into slot position
  assign addr_off = reg_addr - FIRST_SLOT_ADDR;
  assign slot_hit = (reg_addr >= FIRST_SLOT_ADDR)
                    && (reg_addr <= LAST_SLOT_ADDR);
  assign slot_sel = addr_off[2:0];
  // prescaler expiry
  assign step_tick = (prescale_reg == 32'h0000_0000);

  //////////////////////////////////////////////////////////////////////
  // slot registers, host writes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < SLOT_COUNT; i++)
        slot_reg[i] <= SLOT_RESET; // [R8]
    end
    else if (enable && reg_write && slot_hit)
    begin
      slot_reg[slot_sel] <= reg_wdata; // [R8]
    end
  end

  // read data, unmapped reads zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else if (enable && reg_read)
    begin
      if (slot_hit)
        rdata_reg <= slot_reg[slot_sel]; // [R8]
      else
        rdata_reg <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sequencer state and pointer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      ptr_reg <= 3'h0;
    end
    else if (enable)
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          // trigger starts at the first slot
          if (playback_trigger)
          begin
            ptr_reg <= 3'h0; // [R5]
            state_reg <= ST_FETCH; // [R5]
            busy_reg <= 1'b1; // [R5]
          end
        end
        ST_FETCH:
        begin
          // zero identifier ends the sequence
          if (cur_slot[VALUE_MSB:0] == 7'h00)
          begin
            state_reg <= ST_IDLE; // [R7]
            busy_reg <= 1'b0; // [R7]
          end
          else if (cur_slot[DELAY_FLAG_BIT])
            state_reg <= ST_WAIT; // [R1]
          else
            state_reg <= ST_PLAY; // [R3]
        end
        ST_PLAY, ST_WAIT:
        begin
          // slot finished: advance or stop after the eighth
          if ((state_reg == ST_PLAY && effect_done)
              || (state_reg == ST_WAIT && step_tick
                  && delay_reg == 7'h01))
          begin
            if (ptr_reg == 3'h7)
            begin
              state_reg <= ST_IDLE; // [R7]
              busy_reg <= 1'b0; // [R7]
            end
            else
            begin
              ptr_reg <= ptr_reg + 3'h1; // [R6]
              state_reg <= ST_FETCH; // [R6]
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // idle timer: prescaler and step count
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      delay_reg <= 7'h00;
      prescale_reg <= 32'h0000_0000;
    end
    else if (enable)
    begin
      if (state_reg == ST_FETCH && cur_slot[DELAY_FLAG_BIT])
      begin
        delay_reg <= cur_slot[VALUE_MSB:0]; // [R2]
        prescale_reg <= 32'(STEP_LEN - 1); // [R9]
      end
      else if (state_reg == ST_WAIT)
      begin
        if (step_tick)
        begin
          delay_reg <= delay_reg - 7'h01; // [R9]
          prescale_reg <= 32'(STEP_LEN - 1); // [R9]
        end
        else
          prescale_reg <= prescale_reg - 32'h0000_0001; // [R9]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // effect launch toward the playback engine
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      effect_start_reg <= 1'b0;
      effect_index_reg <= 7'h00;
    end
    else if (enable)
    begin
      effect_start_reg <= 1'b0;
      if (state_reg == ST_FETCH && !cur_slot[DELAY_FLAG_BIT]
          && cur_slot[VALUE_MSB:0] != 7'h00)
      begin
        effect_start_reg <= 1'b1; // [R3]
        effect_index_reg <= cur_slot[VALUE_MSB:0]; // [R4]
      end
    end
  end

  // outputs straight from flops
  assign reg_rdata = rdata_reg;
  assign effect_start = effect_start_reg;
  assign effect_index = effect_index_reg;
  assign engine_idling = state_reg[3]; // one-hot wait bit
  assign sequence_busy = busy_reg;
  assign slot_pointer = ptr_reg;

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_wait_silent;
    @(posedge clock) disable iff (rst)
    (state_reg == ST_WAIT) |-> !effect_start_reg;
  endproperty
  a_wait_silent: assert property (p_wait_silent) // [R1]
    else $error("effect launched during idle slot");

  property p_delay_load;
    @(posedge clock) disable iff (rst)
    (enable && state_reg == ST_FETCH && cur_slot[DELAY_FLAG_BIT]
     && cur_slot[VALUE_MSB:0] != 7'h00)
    |=> (state_reg == ST_WAIT)
        && (delay_reg == $past(cur_slot[VALUE_MSB:0]));
  endproperty
  a_delay_load: assert property (p_delay_load) // [R2]
    else $error("idle step count not loaded from slot");

  property p_effect_launch;
    @(posedge clock) disable iff (rst)
    (enable && state_reg == ST_FETCH && !cur_slot[DELAY_FLAG_BIT]
     && cur_slot[VALUE_MSB:0] != 7'h00)
    |=> effect_start_reg && (state_reg == ST_PLAY);
  endproperty
  a_effect_launch: assert property (p_effect_launch) // [R3]
    else $error("effect slot did not launch");

  property p_effect_index;
    @(posedge clock) disable iff (rst)
    $rose(effect_start_reg)
    |-> effect_index_reg == $past(cur_slot[VALUE_MSB:0]);
  endproperty
  a_effect_index: assert property (p_effect_index) // [R4]
    else $error("effect index differs from slot value");

  property p_trigger_start;
    @(posedge clock) disable iff (rst)
    (enable && state_reg == ST_IDLE && playback_trigger)
    |=> (state_reg == ST_FETCH) && (ptr_reg == 3'h0);
  endproperty
  a_trigger_start: assert property (p_trigger_start) // [R5]
    else $error("trigger did not start at first slot");

  property p_advance;
    @(posedge clock) disable iff (rst)
    (enable && state_reg == ST_PLAY && effect_done && ptr_reg != 3'h7)
    |=> (ptr_reg == $past(ptr_reg) + 3'h1) && (state_reg == ST_FETCH);
  endproperty
  a_advance: assert property (p_advance) // [R6]
    else $error("sequencer did not advance to next slot");

  property p_stop;
    @(posedge clock) disable iff (rst)
    (enable && ((state_reg == ST_FETCH && cur_slot[VALUE_MSB:0] == 7'h00)
     || (state_reg == ST_PLAY && effect_done && ptr_reg == 3'h7)))
    |=> state_reg == ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) // [R7]
    else $error("sequence did not end");

  property p_readback;
    @(posedge clock) disable iff (rst)
    (enable && reg_write && slot_hit && !(reg_read))
    ##1 (enable && reg_read && !reg_write
         && reg_addr == $past(reg_addr))
    |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_readback: assert property (p_readback) // [R8]
    else $error("slot readback differs from write");

  property p_step_tick;
    @(posedge clock) disable iff (rst)
    (enable && state_reg == ST_WAIT && !step_tick)
    |=> delay_reg == $past(delay_reg);
  endproperty
  a_step_tick: assert property (p_step_tick) // [R9]
    else $error("idle count moved before step end");

endmodule // waveform_sequencer_slots

// ---- test/effect_engine_model.sv ----
`timescale 1ns/1ps
// effect engine stand-in: ends each effect after a short or long run
module effect_engine_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic slow,
  input wire logic effect_start,
  input wire logic [6:0] effect_index,
  output logic effect_done,
  output int n_started,
  output logic [6:0] last_index
);
  int left; // cycles until the effect ends
  ////////////////////////////////////////////////////////////////
  // count launches, answer with a one-cycle done pulse
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      effect_done <= 1'b0;
      n_started <= 0;
      last_index <= 7'h00;
      left <= 0;
    end
    else
    begin
      effect_done <= (left == 1);
      if (left > 0)
        left <= left - 1;
      if (effect_start)
      begin
        n_started <= n_started + 1;
        last_index <= effect_index;
        left <= slow ? 6 : 1;
      end
    end
  end
endmodule // effect_engine_model

// ---- test/tb.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import sequencer_slots_pkg::*;
  localparam int STEP = 4; // shortened idle step
  logic clock = 0, rst = 1, reg_write = 0, reg_read = 0, trig = 0, slow = 0;
  logic enable = 1; // clock enable of the block
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic effect_done, effect_start, engine_idling, sequence_busy;
  logic [6:0] effect_index, last_index;
  logic [2:0] slot_pointer;
  int n_mismatch = 0, n_tests = 0, n_started, n_idle;
  always #25 clock = ~clock;
  waveform_sequencer_slots #(.STEP_LEN(STEP)) i_waveform_sequencer_slots (
    .clock(clock), .rst(rst), .enable(enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .playback_trigger(trig),
    .effect_done(effect_done), .effect_start(effect_start),
    .effect_index(effect_index), .engine_idling(engine_idling),
    .sequence_busy(sequence_busy), .slot_pointer(slot_pointer));
  effect_engine_model i_effect_engine_model (.clock(clock), .rst(rst),
    .slow(slow), .effect_start(effect_start), .effect_index(effect_index),
    .effect_done(effect_done), .n_started(n_started),
    .last_index(last_index));
  ////////////////////////////////////////////////////////////////
  // one register write, strobe for one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(negedge clock) {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
    @(negedge clock) reg_write = 1'b0;
  end
  endtask
  // one register read, returns data after the next edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(negedge clock) {reg_addr, reg_read} = {a, 1'b1};
    @(negedge clock) reg_read = 1'b0;
    d = reg_rdata;
  end
  endtask
  // write then read back in the very next cycle, same address
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
  begin
    @(negedge clock) {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
    @(negedge clock) {reg_write, reg_read} = 2'b01;
    @(negedge clock) reg_read = 1'b0;
    q = reg_rdata;
  end
  endtask
  // trigger and wait for the end, counting idle cycles
  task automatic run_seq;
    int k;
  begin
    n_idle = 0;
    k = 0;
    @(negedge clock) trig = 1'b1;
    @(negedge clock) trig = 1'b0;
    `CHK(sequence_busy, 1'b1)
    `CHK(slot_pointer, 3'h0)
    while (sequence_busy === 1'b1 && k < 400)
    begin
      @(negedge clock) k++;
      if (engine_idling === 1'b1) n_idle++;
    end
    `CHK(sequence_busy, 1'b0)
  end
  endtask
  ////////////////////////////////////////////////////////////////
  // reset values, read back, unmapped address
  task automatic t_regs;
    logic [7:0] d;
  begin
    rd(SLOT_SIX_ADDR, d); `CHK(d, SLOT_RESET)
    rd(SLOT_SEVEN_ADDR, d); `CHK(d, SLOT_RESET)
    wr(SLOT_SIX_ADDR, 8'ha5);
    wr(SLOT_SEVEN_ADDR, 8'h5a);
    rd(SLOT_SIX_ADDR, d); `CHK(d, 8'ha5)
    rd(SLOT_SEVEN_ADDR, d); `CHK(d, 8'h5a)
    wr_rd(SLOT_SEVEN_ADDR, 8'h81, d); `CHK(d, 8'h81)
    wr(8'h20, 8'hff);
    rd(8'h20, d); `CHK(d, 8'h00)
    // enable low: write must not land, read data must hold
    @(negedge clock) enable = 1'b0;
    wr(SLOT_SIX_ADDR, 8'h3c);
    rd(SLOT_SIX_ADDR, d); `CHK(d, 8'h00)
    enable = 1'b1;
    rd(SLOT_SIX_ADDR, d); `CHK(d, 8'ha5)
    $display("test regs done");
  end
  endtask
  // effect, two-step idle, then a zero slot stops
  task automatic t_mixed;
  begin
    wr(FIRST_SLOT_ADDR, 8'h05);
    wr(8'h10, 8'h82);
    wr(8'h11, 8'h00);
    run_seq();
    `CHK(n_started, 1)
    `CHK(last_index, 7'h05)
    `CHK(n_idle, 2 * STEP)
    `CHK(slot_pointer, 3'h2)
    $display("test mixed done");
  end
  endtask
  // all eight slots played with a slow engine
  task automatic t_full;
  begin
    slow = 1'b1;
    for (int i = 0; i < SLOT_COUNT; i++)
      wr(FIRST_SLOT_ADDR + 8'(i), 8'(i + 1));
    run_seq();
    `CHK(n_started, 1 + SLOT_COUNT)
    `CHK(last_index, 7'h08)
    `CHK(n_idle, 0)
    `CHK(slot_pointer, 3'h7)
    $display("test full done");
  end
  endtask
  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic complete_run;
  begin
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    t_regs();
    t_mixed();
    t_full();
    complete_run();
  end
  // watchdog well past the expected run
  initial
  begin
    #(50 * 5000);
    n_mismatch++;
    complete_run();
  end
endmodule // tb
